//--- verilog/scs_seq.v
// SAR conversion sequencer with AHB-Lite register slave
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_seq (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    input wire [16:0] afe_data,
    output wire afe_sample,
    output wire afe_active,
    output wire afe_diff,
    output wire [1:0] afe_ref_sel,
    output wire async_clk_en,
    output wire irq
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_BUS = 6'h02;
    localparam [5:0] S_WAKE = 6'h04;
    localparam [5:0] S_FIRST = 6'h08;
    localparam [5:0] S_SAMP = 6'h10;
    localparam [5:0] S_CONV = 6'h20;

    reg [`SCS_CFG_W-1:0] cfg_q;
    reg [15:0] ofs_q;
    reg [15:0] gain_q;
    reg [15:0] cv_q;
    reg [1:0] stat_q;
    reg [1:0] ien_q;
    reg [31:0] res_q;
    reg [31:0] hrdata_q;
    reg ap_wr_q;
    reg [7:0] ap_a_q;
    reg irq_q;
    reg smp_q;
    reg act_q;
    reg aclk_q;
    reg [5:0] st_q;
    reg [5:0] st_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;
    reg [5:0] nsmp_q;
    reg [5:0] nsmp_d;
    reg signed [25:0] acc_q;
    reg signed [25:0] acc_d;
    reg set_end;
    reg [7:0] base_conversion_time;
    reg [7:0] lst;
    reg [31:0] rd_mux;
    wire tick;
    wire [19:0] corr;
    wire asel;
    wire keep;
    wire diff;
    wire busy;
    wire ap_ok;
    wire wr_start;
    wire start_w;
    wire abort_w;
    wire rd_res;
    wire [7:0] first_len;
    wire [7:0] samp_len;
    wire [7:0] conv_len;
    wire [5:0] avg_n;
    wire [3:0] ash;
    wire [3:0] wsh;
    wire [3:0] tot;
    wire [4:0] wid;
    wire signed [25:0] sum;
    wire signed [25:0] rnd;
    wire signed [25:0] mean;
    wire signed [25:0] hi;
    wire signed [25:0] lo;
    wire signed [25:0] res_c;
    wire signed [25:0] cv_x;
    wire cmp_ok;
    wire done_ev;
    wire [1:0] ev;
    wire [1:0] clr;
    wire [1:0] stat_d;

    assign asel = cfg_q[`SCS_B_ASEL];
    assign keep = cfg_q[`SCS_B_KEEP];
    assign diff = cfg_q[`SCS_B_DIFF];
    assign busy = (st_q != S_IDLE);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    scs_tick u_tick (
        .clk(hclk),
        .rst_n(hresetn),
        .async_sel(asel),
        .run(~asel | keep | busy),
        .div(cfg_q[`SCS_F_DIV]),
        .tick(tick)
    );

    scs_corr u_corr (
        .raw(afe_data),
        .ofs(ofs_q),
        .gain(gain_q),
        .corr(corr)
    );

    // ----------------------------------------
    // Phase lengths
    // ----------------------------------------
    always @* begin
        case ({diff, cfg_q[`SCS_F_MODE]})
            3'h0: base_conversion_time = `SCS_BCT_SE8;
            3'h1: base_conversion_time = `SCS_BCT_SE10;
            3'h2: base_conversion_time = `SCS_BCT_SE10;
            3'h3: base_conversion_time = `SCS_BCT_SE16;
            3'h4: base_conversion_time = `SCS_BCT_DF9;
            3'h5: base_conversion_time = `SCS_BCT_DF11;
            3'h6: base_conversion_time = `SCS_BCT_DF11;
            default: base_conversion_time = `SCS_BCT_DF16;
        endcase
        case (cfg_q[`SCS_F_LSTS])
            3'h1: lst = `SCS_LST_1;
            3'h2: lst = `SCS_LST_2;
            3'h3: lst = `SCS_LST_3;
            3'h4: lst = `SCS_LST_4;
            default: lst = `SCS_LST_0;
        endcase
        if (!cfg_q[`SCS_B_LSMP]) begin
            lst = `SCS_LST_0;
        end
    end

    assign first_len = cfg_q[`SCS_B_LSMP] ? `SCS_FIRST_LS : `SCS_FIRST_NL;
    assign samp_len = `SCS_SAMP_BASE + lst;
    assign conv_len = base_conversion_time - `SCS_SAMP_BASE + (cfg_q[`SCS_B_HSC] ? `SCS_HS_ADD : 8'h00);
    assign avg_n = cfg_q[`SCS_B_AVERAGING_ENABLE] ? (6'h04 << cfg_q[`SCS_F_AVGS]) : 6'h01;

    // ----------------------------------------
    // Mean, rounding and result format
    // ----------------------------------------
    assign ash = cfg_q[`SCS_B_AVERAGING_ENABLE] ? ({2'h0, cfg_q[`SCS_F_AVGS]} + 4'h2) : 4'h0;
    assign wsh = (cfg_q[`SCS_F_MODE] == 2'h0) ? 4'h8 :
                 (cfg_q[`SCS_F_MODE] == 2'h1) ? 4'h4 :
                 (cfg_q[`SCS_F_MODE] == 2'h2) ? 4'h6 : (diff ? 4'h1 : 4'h0);
    assign tot = ash + wsh;
    assign wid = (diff ? 5'h11 : 5'h10) - {1'b0, wsh};
    assign sum = acc_q + {{6{corr[19]}}, corr};
    assign rnd = (tot == 4'h0) ? 26'sh0 : (26'sh1 <<< (tot - 4'h1));
    assign mean = (sum + rnd) >>> tot;
    assign hi = diff ? ((26'sh1 <<< (wid - 5'h01)) - 26'sh1) : ((26'sh1 <<< wid) - 26'sh1);
    assign lo = diff ? -(26'sh1 <<< (wid - 5'h01)) : 26'sh0;
    assign res_c = (mean > hi) ? hi : ((mean < lo) ? lo : mean);
    assign cv_x = diff ? {{10{cv_q[15]}}, cv_q} : {10'h000, cv_q};
    assign cmp_ok = ~cfg_q[`SCS_B_CMPE] | (cfg_q[`SCS_B_CMPGT] ? (res_c >= cv_x) : (res_c < cv_x));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        st_d = st_q;
        cnt_d = cnt_q;
        nsmp_d = nsmp_q;
        acc_d = acc_q;
        set_end = 1'b0;
        case (st_q)
            S_IDLE: begin
                st_d = S_IDLE;
            end
            S_BUS: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (asel & ~keep) begin
                    st_d = S_WAKE;
                    cnt_d = `SCS_WAKE_CYC - 8'h01;
                end else begin
                    st_d = S_FIRST;
                    cnt_d = first_len - 8'h01;
                end
            end
            S_WAKE: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    st_d = S_FIRST;
                    cnt_d = first_len - 8'h01;
                end
            end
            S_FIRST: begin
                if (tick && cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (tick) begin
                    st_d = S_SAMP;
                    cnt_d = samp_len - 8'h01;
                end
            end
            S_SAMP: begin
                if (tick && cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (tick) begin
                    st_d = S_CONV;
                    cnt_d = conv_len - 8'h01;
                end
            end
            S_CONV: begin
                if (tick && cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (tick && nsmp_q != avg_n - 6'h01) begin
                    acc_d = sum;
                    nsmp_d = nsmp_q + 6'h01;
                    st_d = S_SAMP;
                    cnt_d = samp_len - 8'h01;
                end else if (tick) begin
                    set_end = 1'b1;
                    acc_d = 26'sh0;
                    nsmp_d = 6'h00;
                    st_d = cfg_q[`SCS_B_CONT] ? S_SAMP : S_IDLE;
                    cnt_d = samp_len - 8'h01;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        if (start_w) begin
            st_d = S_BUS;
            cnt_d = `SCS_BUS_ADD - 8'h01;
            nsmp_d = 6'h00;
            acc_d = 26'sh0;
        end else if (abort_w) begin
            st_d = S_IDLE;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            nsmp_q <= 6'h00;
            acc_q <= 26'sh0;
            smp_q <= 1'b0;
            act_q <= 1'b0;
            aclk_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            nsmp_q <= nsmp_d;
            acc_q <= acc_d;
            smp_q <= (st_d == S_SAMP);
            act_q <= (st_d != S_IDLE);
            aclk_q <= asel & (keep | (st_d != S_IDLE));
        end
    end

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    assign ap_ok = hsel & hready & htrans[1];
    assign wr_start = ap_wr_q & (ap_a_q == `SCS_A_START);
    assign start_w = wr_start & hwdata[0];
    assign abort_w = wr_start & ~hwdata[0];
    assign rd_res = ap_ok & ~hwrite & (haddr[7:0] == `SCS_A_RES);

    always @* begin
        case (haddr[7:0])
            `SCS_A_CFG: rd_mux = {12'h000, cfg_q};
            `SCS_A_STAT: rd_mux = {23'h000000, busy, 6'h00, stat_q};
            `SCS_A_IEN: rd_mux = {30'h00000000, ien_q};
            `SCS_A_RES: rd_mux = res_q;
            `SCS_A_OFS: rd_mux = {16'h0000, ofs_q};
            `SCS_A_GAIN: rd_mux = {16'h0000, gain_q};
            `SCS_A_CV: rd_mux = {16'h0000, cv_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_a_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            cfg_q <= `SCS_CFG_RST;
            ofs_q <= `SCS_OFS_RST;
            gain_q <= `SCS_GAIN_RST;
            cv_q <= 16'h0000;
            ien_q <= 2'h0;
        end else begin
            ap_wr_q <= ap_ok & hwrite;
            ap_a_q <= haddr[7:0];
            if (ap_ok & ~hwrite) begin
                hrdata_q <= rd_mux;
            end
            if (ap_wr_q) begin
                case (ap_a_q)
                    `SCS_A_CFG: cfg_q <= hwdata[`SCS_CFG_W-1:0];
                    `SCS_A_IEN: ien_q <= hwdata[1:0];
                    `SCS_A_OFS: ofs_q <= hwdata[15:0];
                    `SCS_A_GAIN: gain_q <= hwdata[15:0];
                    `SCS_A_CV: cv_q <= hwdata[15:0];
                    default: ien_q <= ien_q;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Result, status and interrupt
    // ----------------------------------------
    assign done_ev = set_end & cmp_ok;
    assign ev = {done_ev & stat_q[`SCS_ST_DONE], done_ev};
    assign clr = (ap_wr_q && ap_a_q == `SCS_A_ICLR) ? hwdata[1:0] : {1'b0, rd_res};
    assign stat_d = (stat_q & ~clr) | ev;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= 2'h0;
            res_q <= 32'h00000000;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (done_ev) begin
                res_q <= {{6{res_c[25]}}, res_c};
            end
            irq_q <= |(stat_d & ien_q);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign afe_sample = smp_q;
    assign afe_active = act_q;
    assign afe_diff = diff;
    assign afe_ref_sel = cfg_q[`SCS_F_REF];
    assign async_clk_en = aclk_q;
    assign irq = irq_q;
endmodule

//--- verilog/scs_regs.vh
// Register map, field layout and timing constants of the SAR conversion sequencer
// Summary of operation
// - High-speed setting adds four conversion clock cycles to every conversion.
// - Long sample adds 0, 2, 6, 12 or 20 conversion clock cycles.
// - Total time is first adder plus sample count times per-sample time.
// - Conversion time runs from initiation until the complete flag sets.
// - With averaging, complete flag sets once after the whole 4 to 32 set.
// - One start launches all conversions of an averaging set in hardware.
// - Differential result is right-justified two's complement of 16, 13, 11 or 9 bits.
// - Differential result positive when plus input exceeds minus input, negative when minus input exceeds plus input.
// - Single-ended base time is 17, 20, 20 or 25 conversion clocks.
// - Differential base time is 27, 30, 30 or 34 conversion clocks.
// - Keepalive runs async clock always; otherwise only while converting, with startup delay.
// - Keepalive has no effect while the bus-derived clock is selected.
// - Every conversion subtracts stored offset and multiplies by stored gain.
// - Reference select picks external, bandgap or alternative reference pair.
// - First adder is 3 or 5 conversion clocks plus 5 bus cycles, plus 5 us when the async clock is selected without keepalive.
// - With compare and averaging, flag sets only when both are satisfied.
// - Setting the complete flag with interrupt enabled raises the interrupt.
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCS_A_CFG 8'h00
`define SCS_A_START 8'h04
`define SCS_A_STAT 8'h08
`define SCS_A_IEN 8'h0C
`define SCS_A_ICLR 8'h10
`define SCS_A_RES 8'h14
`define SCS_A_OFS 8'h18
`define SCS_A_GAIN 8'h1C
`define SCS_A_CV 8'h20

// ----------------------------------------
// Configuration fields and reset values
// ----------------------------------------
`define SCS_F_MODE 1:0
`define SCS_B_DIFF 2
`define SCS_B_LSMP 3
`define SCS_F_LSTS 6:4
`define SCS_B_HSC 7
`define SCS_B_AVERAGING_ENABLE 8
`define SCS_F_AVGS 10:9
`define SCS_B_CONT 11
`define SCS_B_ASEL 12
`define SCS_B_KEEP 13
`define SCS_F_REF 15:14
`define SCS_B_CMPE 16
`define SCS_B_CMPGT 17
`define SCS_F_DIV 19:18
`define SCS_CFG_W 20
`define SCS_CFG_RST 20'h00000
`define SCS_GAIN_RST 16'h8000
`define SCS_OFS_RST 16'h0000
`define SCS_ST_DONE 0
`define SCS_ST_OVR 1
`define SCS_ST_BUSY 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCS_CLK_NS 40
`define SCS_WAKE_NS 5000
`define SCS_WAKE_CYC 8'h7D
`define SCS_BUS_ADD 8'h05
`define SCS_FIRST_LS 8'h03
`define SCS_FIRST_NL 8'h05
`define SCS_HS_ADD 8'h04
`define SCS_SAMP_BASE 8'h04
`define SCS_ASYNC_DIV 8'h04
`define SCS_BCT_SE8 8'h11
`define SCS_BCT_SE10 8'h14
`define SCS_BCT_SE16 8'h19
`define SCS_BCT_DF9 8'h1B
`define SCS_BCT_DF11 8'h1E
`define SCS_BCT_DF16 8'h22
`define SCS_LST_0 8'h00
`define SCS_LST_1 8'h02
`define SCS_LST_2 8'h06
`define SCS_LST_3 8'h0C
`define SCS_LST_4 8'h14

`endif

//--- verilog/scs_tick.v
// Conversion clock enable generator for bus-derived and gated async sources
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_tick (
    input wire clk,
    input wire rst_n,
    input wire async_sel,
    input wire run,
    input wire [1:0] div,
    output wire tick
);
    reg [7:0] cnt_q;
    reg tick_q;
    wire [7:0] lim;

    assign lim = async_sel ? (`SCS_ASYNC_DIV - 8'h01) : ((8'h01 << div) - 8'h01);
    assign tick = tick_q;

    // ----------------------------------------
    // Divider, cleared while the clock is gated
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (cnt_q >= lim) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end
endmodule

//--- verilog/scs_corr.v
// Offset and gain correction of one raw sample
`timescale 1ns/100ps
module scs_corr (
    input wire [16:0] raw,
    input wire [15:0] ofs,
    input wire [15:0] gain,
    output wire [19:0] corr
);
    wire signed [17:0] dif;
    wire signed [34:0] prod;

    // Subtract offset, then gain with 0x8000 as unity
    assign dif = $signed({raw[16], raw}) - $signed({{2{ofs[15]}}, ofs});
    assign prod = dif * $signed({1'b0, gain});
    assign corr = prod[34:15];
endmodule

//--- bench/scs_seq_monitor.sv
// Port checker of the SAR conversion sequencer
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_seq_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire hresp,
    input wire [16:0] afe_data,
    input wire afe_sample,
    input wire afe_active,
    input wire afe_diff,
    input wire [1:0] afe_ref_sel,
    input wire async_clk_en,
    input wire irq
);
    // ----
    // Shadow of written settings and phase counters
    // ----
    reg ph_v_q;
    reg [7:0] ph_a_q;
    reg [19:0] cfg_q;
    reg [1:0] ien_q;
    reg s_q;
    reg [11:0] len_q;
    reg [11:0] gap_q;
    reg [7:0] nsmp_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v_q <= 1'b0;
            ph_a_q <= 8'h00;
            cfg_q <= 20'h00000;
            ien_q <= 2'h0;
            s_q <= 1'b0;
            len_q <= 12'h000;
            gap_q <= 12'h000;
            nsmp_q <= 8'h00;
        end else begin
            ph_v_q <= hsel && hready && htrans[1] && hwrite;
            ph_a_q <= haddr[7:0];
            if (ph_v_q && ph_a_q == `SCS_A_CFG) cfg_q <= hwdata[19:0];
            if (ph_v_q && ph_a_q == `SCS_A_IEN) ien_q <= hwdata[1:0];
            s_q <= afe_sample;
            len_q <= afe_sample ? len_q + 12'h001 : 12'h000;
            gap_q <= (afe_sample && !s_q) ? 12'h001 : gap_q + 12'h001;
            nsmp_q <= !afe_active ? 8'h00 : nsmp_q + {7'h00, afe_sample && !s_q};
        end
    end
    function int f_per(input [19:0] c);
        f_per = c[12] ? 4 : (1 << c[19:18]);
    endfunction
    function int f_lst(input [19:0] c);
        f_lst = !c[3] ? 0 : c[6:4] == 1 ? 2 : c[6:4] == 2 ? 6 : c[6:4] == 3 ? 12 : c[6:4] == 4 ? 20 : 0;
    endfunction
    function int f_smp(input [19:0] c);
        f_smp = (c[2] ? (c[1:0] == 0 ? 27 : c[1:0] == 3 ? 34 : 30) : (c[1:0] == 0 ? 17 : c[1:0] == 3 ? 25 : 20))
            + f_lst(c) + (c[7] ? 4 : 0);
    endfunction
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence start_wr;
        ph_v_q && ph_a_q == `SCS_A_START && hwdata[0];
    endsequence
    sequence busy_soon;
        ##[1:3] afe_active;
    endsequence
    AST_START_BUSY: assert property (start_wr |-> busy_soon)
        else $error("start did not make the sequencer busy");
    AST_SAMP_LEN: assert property ($fell(afe_sample) |-> len_q == f_per(cfg_q) * (4 + f_lst(cfg_q)))
        else $error("sampling phase length wrong");
    AST_SAMP_PERIOD: assert property ($rose(afe_sample) && nsmp_q != 8'h00 |-> gap_q == f_per(cfg_q) * f_smp(cfg_q))
        else $error("per-sample time wrong");
    AST_SET_COUNT: assert property ($fell(afe_active) |-> nsmp_q == (cfg_q[8] ? (8'h04 << cfg_q[10:9]) : 8'h01))
        else $error("sample count of set wrong");
    AST_SAMP_IN_ACTIVE: assert property (afe_sample |-> afe_active)
        else $error("sampling while idle");
    AST_KEEP_ON: assert property (cfg_q[12] && cfg_q[13] && $stable(cfg_q) |-> async_clk_en)
        else $error("kept-alive async clock stopped");
    AST_BUS_OFF: assert property (!cfg_q[12] && $stable(cfg_q) |-> !async_clk_en)
        else $error("async clock runs on bus source");
    AST_CFG_OUT: assert property ($stable(cfg_q) |-> afe_diff == cfg_q[2] && afe_ref_sel == cfg_q[15:14])
        else $error("reference or input mode not applied");
    AST_IRQ_MASK: assert property (ien_q == 2'h0 && $stable(ien_q) |-> !irq)
        else $error("masked interrupt raised");
endmodule
bind scs_seq scs_seq_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .afe_data(afe_data), .afe_sample(afe_sample), .afe_active(afe_active), .afe_diff(afe_diff),
    .afe_ref_sel(afe_ref_sel), .async_clk_en(async_clk_en), .irq(irq));

//--- bench/scs_afe_model.sv
// Behavioural analog front end of the sequencer
`timescale 1ns/100ps
module scs_afe_model (
    input wire hclk,
    input wire afe_sample,
    input wire afe_active,
    input wire afe_diff,
    input wire [15:0] plus_v,
    input wire [15:0] minus_v,
    input wire [15:0] step_v,
    output wire [16:0] afe_data
);
    reg s_q;
    reg odd_q;
    wire [16:0] v;
    // Every second sample of a set adds step_v
    always @(posedge hclk) begin
        s_q <= afe_sample;
        if (!afe_active) odd_q <= 1'b0;
        else if (afe_sample && !s_q) odd_q <= ~odd_q;
    end
    // Signed difference in differential mode
    assign v = {1'b0, plus_v} + (odd_q ? 17'h0 : {1'b0, step_v}) - (afe_diff ? {1'b0, minus_v} : 17'h0);
    // Idle front end holds no value
    assign afe_data = afe_active ? v : ~v;
endmodule

//--- bench/scs_seq_tb.sv
// Testbench of the SAR conversion sequencer
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_seq_tb;
    reg hclk, hresetn, hsel, hwrite;
    reg [31:0] haddr, hwdata, r;
    reg [1:0] htrans;
    reg [2:0] hsize;
    reg [15:0] ap, am, ast;
    wire hready, hresp, afe_sample, afe_active, afe_diff, async_clk_en, irq;
    wire [31:0] hrdata;
    wire [16:0] afe_data;
    wire [1:0] afe_ref_sel;
    int num_errors = 0;
    int n_checks = 0;
    int i;
    scs_seq dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .afe_data(afe_data), .afe_sample(afe_sample), .afe_active(afe_active), .afe_diff(afe_diff),
        .afe_ref_sel(afe_ref_sel), .async_clk_en(async_clk_en), .irq(irq));
    scs_afe_model afe_u (.hclk(hclk), .afe_sample(afe_sample), .afe_active(afe_active), .afe_diff(afe_diff),
        .plus_v(ap), .minus_v(am), .step_v(ast), .afe_data(afe_data));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ----
    // Bus and check tasks
    // ----
    task results;
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task bw(input [7:0] a, input [31:0] d);
        xfer(a, 1'b1, d, r);
    endtask
    task rc(input [7:0] a, input [31:0] e);
        xfer(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask
    function int tks(input [19:0] c);
        int b, l, n;
        b = c[2] ? (c[1:0] == 0 ? 27 : c[1:0] == 3 ? 34 : 30) : (c[1:0] == 0 ? 17 : c[1:0] == 3 ? 25 : 20);
        l = !c[3] ? 0 : c[6:4] == 1 ? 2 : c[6:4] == 2 ? 6 : c[6:4] == 3 ? 12 : c[6:4] == 4 ? 20 : 0;
        n = c[8] ? (4 << c[10:9]) : 1;
        tks = (c[3] ? 3 : 5) + n * (b + l + (c[7] ? 4 : 0));
    endfunction
    task run(input [19:0] c, input [15:0] p, m, st, o, g, input [31:0] cv, res, input ok);
        int x, per, n;
        per = c[12] ? 4 : (1 << c[19:18]);
        x = 6 + ((c[12] && !c[13]) ? `SCS_WAKE_CYC : 0) + per * tks(c);
        ap <= p;
        am <= m;
        ast <= st;
        bw(`SCS_A_OFS, {16'h0000, o});
        bw(`SCS_A_GAIN, {16'h0000, g});
        bw(`SCS_A_CV, cv);
        bw(`SCS_A_IEN, 32'h1);
        bw(`SCS_A_CFG, {12'h000, c});
        bw(`SCS_A_START, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < x + per + 9) begin
            @(negedge hclk);
            n++;
        end
        chk({31'h0, irq === ok}, 32'h1);
        if (ok) chk({31'h0, n > x - per && n <= x}, 32'h1);
        xfer(`SCS_A_RES, 1'b0, 32'h0, r);
        if (ok) chk(r, res);
        rc(`SCS_A_STAT, 32'h0);
        bw(`SCS_A_ICLR, 32'h3);
    endtask
    initial begin
        #(`SCS_CLK_NS * 60000);
        num_errors++;
        results;
    end
    // ----
    // Tests
    // ----
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        ap = 16'h0;
        am = 16'h0;
        ast = 16'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rc(`SCS_A_CFG, 32'h0);
        rc(`SCS_A_GAIN, 32'h8000);
        rc(`SCS_A_OFS, 32'h0);
        rc(`SCS_A_STAT, 32'h0);
        rc(8'h3C, 32'h0);
        for (i = 0; i < 3; i++) begin
            bw(`SCS_A_CFG, i << 14);
            rc(`SCS_A_CFG, i << 14);
            chk({30'h0, afe_ref_sel}, i);
        end
        bw(`SCS_A_IEN, 32'h0);
        bw(`SCS_A_CFG, 32'h0);
        bw(`SCS_A_START, 32'h1);
        repeat (40) @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        rc(`SCS_A_STAT, 32'h1);
        bw(`SCS_A_IEN, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        bw(`SCS_A_ICLR, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        run(20'h00000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h40, 1'b1);
        run(20'h00008, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h40, 1'b1);
        run(20'h000CB, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h4000, 1'b1);
        run(20'h00119, 16'h4000, 16'h0, 16'h200, 16'h0, 16'h8000, 32'h0, 32'h410, 1'b1);
        run(20'h003AA, 16'h4000, 16'h0, 16'h400, 16'h0, 16'h8000, 32'h0, 32'h108, 1'b1);
        run(20'h40538, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h80, 1'b1);
        run(20'h00707, 16'h1000, 16'h3000, 16'h0, 16'h0, 16'h8000, 32'h0, 32'hFFFFF000, 1'b1);
        run(20'h00004, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h80, 1'b1);
        run(20'h00005, 16'h0, 16'h4000, 16'h0, 16'h0, 16'h8000, 32'h0, 32'hFFFFFC00, 1'b1);
        run(20'h00006, 16'h2000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h80, 1'b1);
        run(20'h01000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h40, 1'b1);
        run(20'h03000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h40, 1'b1);
        run(20'h02000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h0, 32'h40, 1'b1);
        run(20'h00003, 16'h4000, 16'h0, 16'h0, 16'h1000, 16'h4000, 32'h0, 32'h1800, 1'b1);
        run(20'h30000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h50, 32'h0, 1'b0);
        run(20'h30000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h40, 32'h40, 1'b1);
        run(20'h10000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h8000, 32'h41, 32'h40, 1'b1);
        results;
    end
endmodule
